// *** core/aea_cfg.svh ***
// constants of the apparent energy accumulator: offsets, fields, resets, counts
// assumes a 32-bit word bus with byte addresses and one system clock
`ifndef AEA_CFG_SVH
`define AEA_CFG_SVH
`define AEA_OFS_GAIN 5'h00
`define AEA_OFS_DIV 5'h04
`define AEA_OFS_TOTAL 5'h08
`define AEA_OFS_RDCLR 5'h0C
`define AEA_OFS_LINE 5'h10
`define AEA_OFS_HCYC 5'h14
`define AEA_OFS_IRQEN 5'h18
`define AEA_OFS_IRQST 5'h1C
`define AEA_BIT_HALF 0
`define AEA_BIT_OVF 1
`define AEA_BIT_CYCDONE 2
`define AEA_NUM_EVT 3
`define AEA_RST_GAIN 12'h000
`define AEA_RST_DIV 8'h00
`define AEA_RST_HCYC 16'hFFFF
`define AEA_RST_IRQEN 3'h0
`define AEA_GAIN_FRAC 12
`define AEA_SAMPLE_CLKS 4
`define AEA_ACC_W 49
`define AEA_REG_W 24
`endif

// *** core/aea_pkg.sv ***
// types of the apparent energy accumulator
// constants live in aea_cfg.svh
package aea_pkg;
    typedef enum logic [0:0] {
        AEA_BUS_IDLE = 1'b0,
        AEA_BUS_ANSWER = 1'b1
    } aea_bus_st_t;

    typedef struct packed {
        logic read;
        logic write;
        logic [4:0] address;
        logic [31:0] writedata;
    } aea_bus_req_t;

    typedef struct packed {
        logic half_full;
        logic overflow;
        logic cycle_done;
    } aea_events_t;
endpackage

// *** core/aea_top.sv ***
// apparent energy accumulator: rms product, gain, 49-bit accumulation,
// divider, total / read-clear / line energy registers, event flags
// assumes rms inputs and the zero-crossing pulse are synchronous to clk_sys
//
// The register addresses and the Avalon-MM interface to the registers are this design's own decisions.
`include "aea_cfg.svh"

// Functional notes
// - apparent power is current rms times voltage rms, phase ignored
// - power scaled by one plus signed 12-bit gain over 4096
// - gain 0x7FF adds about half, 0x800 removes about half
// - no offset correction in the power path
// - scaled power summed continuously into 49-bit accumulator
// - one addition every four master clock cycles
// - accumulator addition is signed
// - accumulator divided by unsigned 8-bit divider; zero means one
// - upper 24 bits of divided accumulator form the total register
// - read-clear register returns energy since last read, cleared on read
// - interrupt pin on half full and overflow when enabled
// - half full judged on full 24-bit unsigned range
// - line energy accumulated over whole half line cycles via zero crossings
// - line accumulation always runs, no enable bit
// - line result uses same path and scale as total register
// - half cycle count from 16-bit register, up to 65535
// - periods aligned to voltage channel zero crossings
// - period end sets cycle done flag bit 2, interrupt if enabled
module aea_top
    import aea_pkg::*;
#(
    parameter int RMS_W = 24
) (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic [RMS_W-1:0] current_rms,
    input wire logic [RMS_W-1:0] voltage_rms,
    input wire logic voltage_zero_cross,
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic irq_n_out,
    output logic irq_n_oe
);
    localparam int PW = 24;
    localparam int SW = PW + 2;
    localparam int AW = `AEA_ACC_W;
    localparam int RW = `AEA_REG_W;
    localparam int NE = `AEA_NUM_EVT;

    initial begin
        if (RMS_W < PW / 2 || RMS_W > 32) begin
            $error("aea_top: RMS_W out of range");
        end
    end

    // sample strobe
    logic [1:0] phase;
    logic [1:0] next_phase;
    wire sample_tick = (phase == 2'(`AEA_SAMPLE_CLKS - 1));

    assign next_phase = sample_tick ? 2'h0 : phase + 2'h1;

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            phase <= 2'h0;
        end else begin
            phase <= next_phase;
        end
    end

    // power path
    logic [11:0] gain;
    logic [7:0] divider;
    wire [2*RMS_W-1:0] rms_product = current_rms * voltage_rms;
    // keep the top bits of the product; no offset stage here
    wire [PW-1:0] power = rms_product[2*RMS_W-1 -: PW];
    wire signed [PW:0] power_s = $signed({1'b0, power});
    wire signed [11:0] gain_s = $signed(gain);
    wire signed [PW+12:0] gain_prod = power_s * gain_s;
    wire signed [PW+12:0] gain_frac = gain_prod >>> `AEA_GAIN_FRAC;
    // one plus gain over 4096, and
    wire signed [SW-1:0] scaled =
        SW'(power_s) + gain_frac[SW-1:0];
    wire signed [AW-1:0] scaled_ext = AW'(scaled);

    // accumulators
    logic signed [AW-1:0] acc;
    logic signed [AW-1:0] line_acc;
    wire signed [AW-1:0] next_acc = acc + scaled_ext;
    wire signed [AW-1:0] line_sum = line_acc + scaled_ext;

    // divider of zero acts as one
    wire [7:0] div_eff = (divider == 8'h00) ? 8'h01 : divider;

    function automatic logic [RW-1:0] div_top(
        input logic [AW-1:0] value,
        input logic [7:0] dv
    );
        logic [AW-2:0] q;
        q = value[AW-2:0] / {40'h0, dv};
        div_top = q[AW-2 -: RW];
    endfunction

    // total register is the upper 24 bits, wraps freely
    wire [RW-1:0] next_total = div_top(next_acc, div_eff);

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            acc <= '0;
        end else if (sample_tick) begin
            acc <= next_acc;
        end
    end

    logic [RW-1:0] total;
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            total <= '0;
        end else begin
            total <= next_total;
        end
    end

    // events on the unsigned 24-bit register
    wire ev_half = total[RW-1] == 1'b0 && next_total[RW-1] == 1'b1;
    wire ev_ovf = total[RW-1] == 1'b1 && next_total[RW-1] == 1'b0;

    // line accumulation: always on
    logic [15:0] halfcycle_count;
    logic [15:0] hc_seen;
    logic [RW-1:0] line_energy;
    wire [15:0] hc_target = (halfcycle_count == 16'h0) ? 16'h1 : halfcycle_count;
    // periods close on voltage zero crossings, and
    wire period_end = voltage_zero_cross && (hc_seen + 16'h1 >= hc_target);
    wire signed [AW-1:0] line_in = sample_tick ? line_sum : line_acc;

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            line_acc <= '0;
            hc_seen <= 16'h0;
        end else if (period_end) begin
            line_acc <= '0;
            hc_seen <= 16'h0;
        end else begin
            line_acc <= line_in;
            if (voltage_zero_cross) begin
                hc_seen <= hc_seen + 16'h1;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            line_energy <= '0;
        end else if (period_end) begin
            // same divider and bit slice as the total
            line_energy <= div_top(line_in, div_eff);
        end
    end

    // bus slave: one answer cycle after the request is seen
    aea_bus_req_t req;
    aea_bus_st_t bus_st;
    aea_bus_st_t next_bus_st;
    assign req = '{read: avs_read, write: avs_write, address: avs_address,
                   writedata: avs_writedata};
    wire req_any = req.read || req.write;
    wire latch = req_any && bus_st == AEA_BUS_IDLE;
    wire accept = req_any && bus_st == AEA_BUS_ANSWER;
    wire wr_acc = accept && req.write;
    wire rd_latch = latch && req.read;

    assign next_bus_st = latch ? AEA_BUS_ANSWER : AEA_BUS_IDLE;

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            bus_st <= AEA_BUS_IDLE;
            avs_waitrequest <= 1'b1;
        end else begin
            bus_st <= next_bus_st;
            avs_waitrequest <= ~latch;
        end
    end

    wire sel_gain = req.address == `AEA_OFS_GAIN;
    wire sel_div = req.address == `AEA_OFS_DIV;
    wire sel_total = req.address == `AEA_OFS_TOTAL;
    wire sel_rdclr = req.address == `AEA_OFS_RDCLR;
    wire sel_line = req.address == `AEA_OFS_LINE;
    wire sel_hcyc = req.address == `AEA_OFS_HCYC;
    wire sel_irqen = req.address == `AEA_OFS_IRQEN;
    wire sel_irqst = req.address == `AEA_OFS_IRQST;

    // read-clear energy is the total minus the total at the last read
    logic [RW-1:0] rc_base;
    wire [RW-1:0] rc_value = total - rc_base;

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            rc_base <= '0;
        end else if (rd_latch && sel_rdclr) begin
            rc_base <= total;
        end
    end

    logic [NE-1:0] irq_en;
    logic [NE-1:0] irq_st;

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            gain <= `AEA_RST_GAIN;
            divider <= `AEA_RST_DIV;
            halfcycle_count <= `AEA_RST_HCYC;
            irq_en <= `AEA_RST_IRQEN;
        end else if (wr_acc) begin
            if (sel_gain) begin
                gain <= req.writedata[11:0];
            end
            if (sel_div) begin
                divider <= req.writedata[7:0];
            end
            if (sel_hcyc) begin
                halfcycle_count <= req.writedata[15:0];
            end
            if (sel_irqen) begin
                irq_en <= req.writedata[NE-1:0];
            end
        end
    end

    wire [31:0] rd_mux =
        sel_gain ? {20'h0, gain} :
        sel_div ? {24'h0, divider} :
        sel_total ? {8'h0, total} :
        sel_rdclr ? {8'h0, rc_value} :
        sel_line ? {8'h0, line_energy} :
        sel_hcyc ? {16'h0, halfcycle_count} :
        sel_irqen ? {29'h0, irq_en} :
        sel_irqst ? {29'h0, irq_st} :
        32'h0;

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            avs_readdata <= 32'h0;
        end else if (rd_latch) begin
            avs_readdata <= rd_mux;
        end
    end

    // sticky event flags, write one to clear; a set in the same cycle wins
    aea_events_t ev;
    assign ev = '{half_full: ev_half, overflow: ev_ovf, cycle_done: period_end};
    wire [NE-1:0] ev_vec;
    assign ev_vec[`AEA_BIT_HALF] = ev.half_full;
    assign ev_vec[`AEA_BIT_OVF] = ev.overflow;
    assign ev_vec[`AEA_BIT_CYCDONE] = ev.cycle_done;
    wire st_clr = wr_acc && sel_irqst;

    genvar gi;
    generate
        for (gi = 0; gi < NE; gi++) begin : g_flag
            always_ff @(posedge clk_sys) begin
                if (srst) begin
                    irq_st[gi] <= 1'b0;
                end else if (ev_vec[gi]) begin
                    irq_st[gi] <= 1'b1;
                end else if (st_clr && req.writedata[gi]) begin
                    irq_st[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    // open-drain pin: only ever pulls low
    wire irq_active = |(irq_st & irq_en);

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            irq_n_out <= 1'b0;
            irq_n_oe <= 1'b0;
        end else begin
            irq_n_out <= 1'b0;
            irq_n_oe <= irq_active;
        end
    end
endmodule

// *** verif/aea_top_properties.sv ***
// port assertions for aea_top
// bound into every aea_top; one clock, synchronous reset
module aea_top_properties #(
    parameter int RMS_W = 24
) (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic [RMS_W-1:0] current_rms,
    input wire logic [RMS_W-1:0] voltage_rms,
    input wire logic voltage_zero_cross,
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic irq_n_out,
    input wire logic irq_n_oe
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (srst);
    wait_one_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("request not answered after one wait cycle");
    low_once_a: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low for more than one cycle");
    answer_cause_a: assert property (!avs_waitrequest |-> $past(avs_read || avs_write))
        else $error("answer without a request");
    rd_hold_a: assert property (!(avs_read && avs_waitrequest) |=> $stable(avs_readdata))
        else $error("readdata changed without a read");
    top_zero_a: assert property (avs_readdata[31:24] == 8'h00)
        else $error("readdata upper byte not zero");
    irq_pin_a: assert property (irq_n_out == 1'b0)
        else $error("interrupt data level not low");
    rst_quiet_a: assert property (disable iff (1'b0) srst |=> avs_waitrequest && !irq_n_oe)
        else $error("reset left bus or interrupt active");
    // interrupt only drops by a write or a reset; it never times out
    irq_clear_a: assert property ($fell(irq_n_oe) |->
        $past(avs_write) || $past(avs_write, 2) || $past(avs_write, 3) || $past(srst))
        else $error("interrupt released without a write");
endmodule
bind aea_top aea_top_properties #(.RMS_W(RMS_W)) u_props (.clk_sys(clk_sys), .srst(srst),
    .current_rms(current_rms), .voltage_rms(voltage_rms), .voltage_zero_cross(voltage_zero_cross),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .irq_n_out(irq_n_out), .irq_n_oe(irq_n_oe));

// *** verif/tb_top.sv ***
// self-checking bench for aea_top: registers, line energy, status, interrupt
// bench drives all ports; rms 0x800000 squared gives 2^22 per addition
`include "aea_cfg.svh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_sys = 0, srst = 1, voltage_zero_cross = 0, avs_read = 0, avs_write = 0;
    logic [23:0] current_rms = '0, voltage_rms = '0;
    logic [4:0] avs_address = '0;
    logic [31:0] avs_writedata = '0, avs_readdata;
    logic avs_waitrequest, irq_n_out, irq_n_oe;
    logic [63:0] pend[$], note;
    int err_total = 0, n_tests = 0, seed = 51911;
    // gain, divider, line energy after 400 additions
    logic [31:0] tbl [5] = '{32'h00000064, 32'h80000032, 32'h7FF00095, 32'h00003021, 32'h00001064};
    aea_top #(.RMS_W(24)) dut (.clk_sys(clk_sys), .srst(srst), .current_rms(current_rms),
        .voltage_rms(voltage_rms), .voltage_zero_cross(voltage_zero_cross),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .irq_n_out(irq_n_out), .irq_n_oe(irq_n_oe));
    initial forever #25 clk_sys = ~clk_sys;
    task automatic chk_val(input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH readdata expected %h seen %h", exp, got);
        end
    endtask
    task automatic chk_pin(input logic exp);
        n_tests++;
        if (irq_n_oe !== exp) begin
            err_total++;
            $display("MISMATCH irq_n_oe expected %b seen %b", exp, irq_n_oe);
        end
    endtask
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // one edge gap first so back-to-back calls never drive twice in a step
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        avs_address <= a;
        avs_writedata <= d;
        avs_read <= ~wr;
        avs_write <= wr;
        do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic rd(input logic [4:0] a, input logic [31:0] exp, input logic [31:0] msk);
        pend.push_back({msk, exp});
        bus(1'b0, a, 32'h0);
    endtask
    // k clocks between crossings, a multiple of 4 so additions per span are exact
    task automatic period(input int k);
        @(posedge clk_sys);
        voltage_zero_cross <= 1'b1;
        @(posedge clk_sys);
        voltage_zero_cross <= 1'b0;
        repeat (k - 2) @(posedge clk_sys);
    endtask
    always @(posedge clk_sys) begin
        if (avs_read === 1'b1 && avs_waitrequest === 1'b0 && pend.size() > 0) begin
            note = pend.pop_front();
            chk_val(note[31:0] & note[63:32], avs_readdata & note[63:32]);
        end
    end
    initial begin
        fork
            begin
                #5ms;
                err_total++;
                $display("watchdog expired");
                conclude();
            end
        join_none
        repeat (20) @(posedge clk_sys);
        srst <= 1'b0;
        for (int i = 0; i < 8; i++) rd(5'(i * 4), (i == 5) ? 32'hFFFF : 32'h0, '1);
        $display("test reset values done");
        current_rms <= 24'h800000;
        voltage_rms <= 24'h800000;
        bus(1'b1, `AEA_OFS_HCYC, 32'h1);
        for (int i = 0; i < 5; i++) begin
            bus(1'b1, `AEA_OFS_GAIN, {20'h0, tbl[i][31:20]});
            bus(1'b1, `AEA_OFS_DIV, {24'h0, tbl[i][19:12]});
            rd(`AEA_OFS_GAIN, {20'h0, tbl[i][31:20]}, '1);
            repeat (3) period(1600);
            rd(`AEA_OFS_LINE, {20'h0, tbl[i][11:0]}, '1);
        end
        $display("test gain and divider done");
        rd(`AEA_OFS_IRQST, 32'h4, 32'h7);
        chk_pin(1'b0);
        bus(1'b1, `AEA_OFS_IRQST, 32'h4);
        rd(`AEA_OFS_IRQST, 32'h0, 32'h4);
        bus(1'b1, `AEA_OFS_IRQEN, 32'h4);
        repeat (2) period(1600);
        chk_pin(1'b1);
        bus(1'b1, `AEA_OFS_IRQST, 32'h4);
        repeat (3) @(posedge clk_sys);
        chk_pin(1'b0);
        $display("test status and interrupt done");
        bus(1'b1, `AEA_OFS_HCYC, 32'h2);
        repeat (6) period(800);
        rd(`AEA_OFS_LINE, 32'h64, '1);
        $display("test half cycle count done");
        current_rms <= 24'h0;
        repeat (6) begin
            voltage_rms <= 24'($random(seed));
            period(800);
        end
        rd(`AEA_OFS_LINE, 32'h0, '1);
        rd(`AEA_OFS_RDCLR, 32'h0, 32'h0);
        rd(`AEA_OFS_RDCLR, 32'h0, '1);
        $display("test zero power and read clear done");
        repeat (2) @(posedge clk_sys);
        conclude();
    end
endmodule
